// File: core/vts_pkg.sv
// Constants, register map and carrier types of the valve travel supervisor.
// Assumes one 200 MHz clock; travel and set point are signed 16-bit
// values in units of 0.01 percent of ranged travel.
package vts_pkg;

    // Clock and control update timing
    localparam int unsigned CLK_HZ = 200_000_000; // System clock rate
    localparam int unsigned UPDATE_US = 100; // Control update period, us
    localparam int unsigned UPDATE_CYC = CLK_HZ / 1_000_000 * UPDATE_US;
    localparam int unsigned UPD_PER_S = 1_000_000 / UPDATE_US; // Per second

    // Travel scale
    localparam logic signed [15:0] DRIVE_MAX = 16'sh2710; // 100.00 %
    localparam logic signed [15:0] DRIVE_MIN = 16'sh0000; // 0.00 %
    localparam logic [8:0] RATE_MAX_S = 9'h190; // 400 s ceiling

    // Register byte offsets
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_PROT = 8'h04;
    localparam logic [7:0] REG_MIN_OPEN = 8'h08;
    localparam logic [7:0] REG_MIN_CLOSE = 8'h0C;
    localparam logic [7:0] REG_FILT = 8'h10;
    localparam logic [7:0] REG_CUT_HI = 8'h14;
    localparam logic [7:0] REG_CUT_LO = 8'h18;
    localparam logic [7:0] REG_ZCS = 8'h1C;
    localparam logic [7:0] REG_AL_DB = 8'h20;
    localparam logic [7:0] REG_AL_BASE = 8'h24; // Hi, HiHi, Lo, LoLo
    localparam logic [7:0] REG_ACC_DB = 8'h34;
    localparam logic [7:0] REG_ACC_PT = 8'h38;
    localparam logic [7:0] REG_ACC = 8'h3C;
    localparam logic [7:0] REG_CAL = 8'h40;
    localparam logic [7:0] REG_STATUS = 8'h44;
    localparam logic [7:0] REG_ISTAT = 8'h48;
    localparam logic [7:0] REG_IMASK = 8'h4C;
    localparam logic [7:0] REG_TRAVEL = 8'h50;
    localparam logic [7:0] REG_DRIVE = 8'h54;

    // Field positions
    localparam int MODE_SVC = 0; // Mode: in service
    localparam int MODE_SEC = 1; // Mode: secondary master
    localparam int NUM_AL = 4; // Travel alert count
    localparam int NUM_EV = 8; // Interrupt event count
    localparam int EV_ACC = 4; // Accumulator alert raised
    localparam int EV_CUT = 5; // Cutoff entered
    localparam int EV_REFUSE = 6; // Protected write refused
    localparam int EV_REJECT = 7; // Return to service rejected

    // Reset values
    localparam logic signed [15:0] CUT_HI_RST = 16'sh30D4; // 125 %
    localparam logic signed [15:0] CUT_LO_RST = 16'shF63C; // -25 %
    localparam logic signed [15:0] AL_HIGH_RST = 16'sh30D4; // 125 %
    localparam logic signed [15:0] AL_LOW_RST = 16'shF63C; // -25 %
    localparam logic signed [15:0] AL_DB_RST = 16'sh01F4; // 5 %
    localparam logic [15:0] ACC_DB_RST = 16'h01F4; // 5 %
    localparam logic [31:0] ACC_PT_RST = 32'hFFFFFFFF; // Never alerts

    // Carrier types
    typedef logic signed [15:0] vts_pos_t; // Travel in 0.01 %

    typedef struct packed {
        logic [8:0] open_s; // Minimum opening time, s
        logic [8:0] close_s; // Minimum closing time, s
    } vts_lim_t;

    typedef struct packed {
        vts_pos_t point; // Alert threshold
        vts_pos_t dband; // Clearing deadband
    } vts_thr_t;

endpackage : vts_pkg

// File: core/vts_rate_limit.sv
// Travel rate limiter: moves one LSB every T control updates.
// Assumes an update strobe from the supervisor on the same clock.
`timescale 1ns/100ps
module vts_rate_limit
    import vts_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic step, // Control update strobe
    input wire logic bypass, // Travel beyond a cutoff
    input vts_pos_t target, // Filtered set point
    input vts_lim_t lim, // Minimum open and close times
    output vts_pos_t pos // Rate-limited target
);

    logic [8:0] cnt_reg; // Updates since last step
    vts_pos_t pos_reg; // Current limited value
    logic up; // Moving toward open
    logic [8:0] lim_t; // Active minimum time

    // Direction picks the opening or closing time
    always_comb
    begin
        up = target > pos_reg;
        lim_t = up ? lim.open_s : lim.close_s;
    end

    // One LSB per lim_t updates gives full range in lim_t seconds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pos_reg <= DRIVE_MIN;
            cnt_reg <= '0;
        end
        else if (ce && step)
        begin
            if (bypass || target == pos_reg || lim_t == '0)
            begin
                pos_reg <= target;
                cnt_reg <= '0;
            end
            else if (cnt_reg + 9'h001 >= lim_t)
            begin
                pos_reg <= up ? pos_reg + 16'sh0001
                              : pos_reg - 16'sh0001;
                cnt_reg <= '0;
            end
            else
            begin
                cnt_reg <= cnt_reg + 9'h001; // Wait for next step
            end
        end
    end

    assign pos = pos_reg;

endmodule : vts_rate_limit

// File: core/vts_alarm.sv
// Travel alert with hysteresis, high or low sense.
// Assumes the travel sample is stable across the evaluation strobe.
`timescale 1ns/100ps
module vts_alarm
    import vts_pkg::*;
#(
    parameter bit HIGH = 1'b1 // 1: trips above point
)
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic eval, // Control update strobe
    input vts_pos_t trv, // Sampled ranged travel
    input vts_thr_t thr, // Point and deadband
    output logic active // Alert level
);

    logic active_reg; // Alert state
    logic signed [17:0] t_w; // Widened travel
    logic signed [17:0] p_w; // Widened point
    logic signed [17:0] d_w; // Widened deadband

    // Widen to avoid overflow at the range ends
    always_comb
    begin
        t_w = 18'(trv);
        p_w = 18'(thr.point);
        d_w = 18'(thr.dband);
    end

    // Set past the point, clear only past point minus deadband (high) or point plus deadband (low)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_reg <= 1'b0;
        else if (ce && eval)
        begin
            if (HIGH)
            begin
                if (t_w > p_w)
                    active_reg <= 1'b1;
                else if (t_w < p_w - d_w)
                    active_reg <= 1'b0;
            end
            else
            begin
                if (t_w < p_w)
                    active_reg <= 1'b1;
                else if (t_w > p_w + d_w)
                    active_reg <= 1'b0;
            end
        end
    end

    assign active = active_reg;

endmodule : vts_alarm

// File: core/vts_supervisor.sv
// Valve travel supervisor: mode, protection, set point filter, rate
// limits, cutoffs, travel accumulator and alerts behind an APB slave.
// Assumes set point and travel codes arrive asynchronously from pins.
//
// Functional notes
// - In service, output follows every set point change
// - Out of service, set point holds; travel beyond a cutoff still forces drive
// - Protection refuses setup and calibration writes
// - Only the same master type returns service
// - Decrease rate limited by minimum closing time
// - Increase rate limited by minimum opening time
// - Set point passes first-order filter, set time constant
// - Accumulate travel change past deadband; zero write resets
// - Deadband re-centred on travel at each increment
// - Accumulator alert set above point, cleared by reset
// - Travel alerts clear only past point minus deadband (hi, hihi) or point plus deadband (lo, lolo)
// - Four independent travel alerts: hi, hihi, lo, lolo
// - Beyond a cutoff, drive forced to max or min
// - Rate limits suspended while beyond a cutoff
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
module vts_supervisor
    import vts_pkg::*;
#(
    parameter int unsigned UPD_CYCLES = UPDATE_CYC // Cycles per update
)
(
    input wire logic pclk, // System clock, 200 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic ce, // Clock enable, freezes all state
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [15:0] ain_code, // Analog set point code, pin
    input wire logic [15:0] travel_code, // Travel sensor code, pin
    output logic [15:0] drive, // Drive signal
    output logic irq // Interrupt, active high level
);

    // Offset is a mapped register
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= REG_DRIVE);
    endfunction : addr_ok

    // Offset is a protected setup or calibration register
    function automatic logic is_setup(input logic [7:0] a);
        is_setup = (a >= REG_MIN_OPEN) && (a <= REG_ACC_PT)
                   || (a == REG_CAL);
    endfunction : is_setup

    // Bus decode
    logic acc_ph; // APB access phase
    logic wr; // Write takes effect
    logic setup_wr; // Unprotected setup write
    // Synchronisers
    logic [15:0] ain_s1, ain_s2; // Set point sync stages
    logic [15:0] trv_s1, trv_s2; // Travel sync stages
    // Update timing
    logic [15:0] upd_cnt_reg; // Update period counter
    logic tick; // Sample strobe
    logic eval_reg; // Evaluate strobe, one after tick
    // Mode and protection
    logic in_svc_reg; // In service
    logic owner_reg; // Master type that took it out
    logic prot_reg; // Configuration and calibration locked
    // Setup registers
    vts_lim_t lim_reg; // Minimum times
    logic [7:0] filt_reg; // Filter time, s
    vts_pos_t cut_hi_reg, cut_lo_reg; // Cutoffs
    logic zcs_reg; // Zero control signal opens valve
    vts_pos_t al_db_reg; // Travel alert deadband
    vts_pos_t al_pt_reg [NUM_AL]; // Travel alert points
    logic [15:0] acc_db_reg; // Accumulator deadband
    logic [31:0] acc_pt_reg; // Accumulator alert point
    vts_pos_t cal_reg; // Travel calibration offset
    // Datapath
    vts_pos_t trv_reg; // Sampled ranged travel
    vts_pos_t sp_reg; // Held set point
    vts_pos_t filt_out_reg; // Filtered set point
    logic signed [31:0] facc_reg; // Filter residue
    vts_pos_t tgt; // Rate-limited target
    vts_pos_t drive_reg; // Drive output
    logic beyond_hi, beyond_lo; // Beyond cutoffs
    logic beyond_d_reg; // Beyond, previous update
    logic [31:0] acc_reg; // Travel accumulator
    vts_pos_t ref_reg; // Accumulator reference
    logic acc_alert_reg; // Accumulator alert
    logic [NUM_AL-1:0] al_act, al_prev_reg; // Travel alerts
    logic acc_prev_reg; // Accumulator alert, previous
    // Interrupts
    logic [NUM_EV-1:0] ev, istat_reg, imask_reg; // Events, sticky, mask
    logic irq_reg; // Interrupt level
    logic [31:0] rd_next, prdata_reg; // Read data

    // Bus strobes; writes take effect at the access edge
    always_comb
    begin
        acc_ph = psel && penable;
        wr = ce && acc_ph && pwrite && addr_ok(paddr);
        setup_wr = wr && is_setup(paddr) && !prot_reg;
    end

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ain_s1 <= '0;
            ain_s2 <= '0;
            trv_s1 <= '0;
            trv_s2 <= '0;
        end
        else if (ce)
        begin
            ain_s1 <= ain_code;
            ain_s2 <= ain_s1;
            trv_s1 <= travel_code;
            trv_s2 <= trv_s1;
        end
    end

    // Control update period
    assign tick = ce && (upd_cnt_reg == 16'(UPD_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            upd_cnt_reg <= '0;
            eval_reg <= 1'b0;
        end
        else if (ce)
        begin
            upd_cnt_reg <= tick ? '0 : upd_cnt_reg + 16'h0001;
            eval_reg <= tick;
        end
    end

    // Sample travel and set point once per update
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trv_reg <= DRIVE_MIN;
            sp_reg <= DRIVE_MIN;
        end
        else if (tick)
        begin
            trv_reg <= vts_pos_t'(trv_s2) + cal_reg;
            if (in_svc_reg)
                sp_reg <= vts_pos_t'(ain_s2);
            else
                sp_reg <= sp_reg;
        end
    end

    // Service mode owned by the master type that took it out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_svc_reg <= 1'b1;
            owner_reg <= 1'b0;
            prot_reg <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == REG_PROT)
                prot_reg <= pwdata[0];
            if (paddr == REG_MODE && !pwdata[MODE_SVC] && in_svc_reg)
            begin
                in_svc_reg <= 1'b0;
                owner_reg <= pwdata[MODE_SEC];
            end
            else if (paddr == REG_MODE && pwdata[MODE_SVC]
                     && pwdata[MODE_SEC] == owner_reg)
                in_svc_reg <= 1'b1;
        end
    end

    // Setup and calibration registers, locked by protection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lim_reg <= '0;
            filt_reg <= '0;
            cut_hi_reg <= CUT_HI_RST;
            cut_lo_reg <= CUT_LO_RST;
            zcs_reg <= 1'b0;
            al_db_reg <= AL_DB_RST;
            for (int i = 0; i < NUM_AL; i++)
                al_pt_reg[i] <= (i < 2) ? AL_HIGH_RST : AL_LOW_RST;
            acc_db_reg <= ACC_DB_RST;
            acc_pt_reg <= ACC_PT_RST;
            cal_reg <= '0;
        end
        else if (setup_wr)
        begin
            case (paddr)
                REG_MIN_OPEN: lim_reg.open_s <= (pwdata[8:0] > RATE_MAX_S)
                    ? RATE_MAX_S : pwdata[8:0];
                REG_MIN_CLOSE: lim_reg.close_s <= (pwdata[8:0] > RATE_MAX_S)
                    ? RATE_MAX_S : pwdata[8:0];
                REG_FILT: filt_reg <= pwdata[7:0];
                REG_CUT_HI: cut_hi_reg <= pwdata[15:0];
                REG_CUT_LO: cut_lo_reg <= pwdata[15:0];
                REG_ZCS: zcs_reg <= pwdata[0];
                REG_AL_DB: al_db_reg <= pwdata[15:0];
                REG_ACC_DB: acc_db_reg <= pwdata[15:0];
                REG_ACC_PT: acc_pt_reg <= pwdata;
                REG_CAL: cal_reg <= pwdata[15:0];
                default:
                    for (int i = 0; i < NUM_AL; i++)
                        if (paddr == REG_AL_BASE + 8'(4 * i))
                            al_pt_reg[i] <= pwdata[15:0];
            endcase
        end
    end

    // First-order filter: residue integrates error, one LSB per overflow
    always_ff @(posedge pclk or negedge presetn)
    begin
        logic signed [31:0] sum;
        logic signed [31:0] n;
        sum = facc_reg + 32'(sp_reg - filt_out_reg);
        n = $signed(32'(filt_reg) * 32'(UPD_PER_S));
        if (!presetn)
        begin
            filt_out_reg <= DRIVE_MIN;
            facc_reg <= '0;
        end
        else if (ce && eval_reg)
        begin
            if (filt_reg == '0)
            begin
                filt_out_reg <= sp_reg; // Filter off
                facc_reg <= '0;
            end
            else if (sum >= n)
            begin
                filt_out_reg <= filt_out_reg + 16'sh0001;
                facc_reg <= sum - n;
            end
            else if (sum <= -n)
            begin
                filt_out_reg <= filt_out_reg - 16'sh0001;
                facc_reg <= sum + n;
            end
            else
                facc_reg <= sum;
        end
    end

    // Cutoff compare on the shared sample
    always_comb
    begin
        beyond_hi = trv_reg > cut_hi_reg;
        beyond_lo = trv_reg < cut_lo_reg;
    end

    // Rate limits, suspended beyond a cutoff
    vts_rate_limit u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .step(eval_reg),
        .bypass(beyond_hi || beyond_lo),
        .target(filt_out_reg),
        .lim(lim_reg),
        .pos(tgt)
    );

    // Drive follows target, forced at the cutoffs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_reg <= DRIVE_MIN;
            beyond_d_reg <= 1'b0;
        end
        else if (ce && eval_reg)
        begin
            beyond_d_reg <= beyond_hi || beyond_lo;
            if (beyond_hi)
                drive_reg <= zcs_reg ? DRIVE_MIN : DRIVE_MAX;
            else if (beyond_lo)
                drive_reg <= zcs_reg ? DRIVE_MAX : DRIVE_MIN;
            else
                drive_reg <= tgt;
        end
    end

    // Travel accumulator; a software write wins over an increment
    always_ff @(posedge pclk or negedge presetn)
    begin
        logic signed [17:0] diff;
        logic [17:0] mag;
        diff = 18'(trv_reg) - 18'(ref_reg);
        mag = diff[17] ? 18'(-diff) : 18'(diff);
        if (!presetn)
        begin
            acc_reg <= '0;
            ref_reg <= DRIVE_MIN;
        end
        else if (wr && paddr == REG_ACC)
        begin
            acc_reg <= pwdata;
            ref_reg <= trv_reg;
        end
        else if (ce && eval_reg && mag > 18'(acc_db_reg))
        begin
            acc_reg <= acc_reg + 32'(mag);
            ref_reg <= trv_reg;
        end
    end

    // Accumulator alert; a reset write judges the new value, not the old
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_alert_reg <= 1'b0;
        else if (wr && paddr == REG_ACC)
            acc_alert_reg <= acc_alert_reg && (pwdata > acc_pt_reg);
        else if (ce && eval_reg && acc_reg > acc_pt_reg)
            acc_alert_reg <= 1'b1;
    end

    // Four travel alerts: hi, hihi trip high; lo, lolo trip low
    generate
        for (genvar g = 0; g < NUM_AL; g++)
        begin : g_alert
            vts_alarm #(.HIGH(g < 2)) u_alarm (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .eval(eval_reg),
                .trv(trv_reg),
                .thr(vts_thr_t'{point: al_pt_reg[g], dband: al_db_reg}),
                .active(al_act[g])
            );
        end
    endgenerate

    // Interrupt events
    always_comb
    begin
        ev = '0;
        ev[NUM_AL-1:0] = al_act & ~al_prev_reg;
        ev[EV_ACC] = acc_alert_reg && !acc_prev_reg;
        ev[EV_CUT] = ce && eval_reg && (beyond_hi || beyond_lo)
                     && !beyond_d_reg;
        ev[EV_REFUSE] = wr && is_setup(paddr) && prot_reg;
        ev[EV_REJECT] = wr && paddr == REG_MODE && pwdata[MODE_SVC]
                        && !in_svc_reg && pwdata[MODE_SEC] != owner_reg;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            istat_reg <= '0;
            imask_reg <= '0;
            al_prev_reg <= '0;
            acc_prev_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else if (ce)
        begin
            al_prev_reg <= al_act;
            acc_prev_reg <= acc_alert_reg;
            if (wr && paddr == REG_IMASK)
                imask_reg <= pwdata[NUM_EV-1:0];
            istat_reg <= (istat_reg & ~((wr && paddr == REG_ISTAT)
                         ? pwdata[NUM_EV-1:0] : '0)) | ev;
            irq_reg <= |(istat_reg & imask_reg);
        end
    end

    // Read mux
    always_comb
    begin
        rd_next = '0;
        case (paddr)
            REG_MODE: rd_next = {30'h0, owner_reg, in_svc_reg};
            REG_PROT: rd_next = {31'h0, prot_reg};
            REG_MIN_OPEN: rd_next = 32'(lim_reg.open_s);
            REG_MIN_CLOSE: rd_next = 32'(lim_reg.close_s);
            REG_FILT: rd_next = 32'(filt_reg);
            REG_CUT_HI: rd_next = {16'h0, cut_hi_reg};
            REG_CUT_LO: rd_next = {16'h0, cut_lo_reg};
            REG_ZCS: rd_next = {31'h0, zcs_reg};
            REG_AL_DB: rd_next = {16'h0, al_db_reg};
            REG_ACC_DB: rd_next = {16'h0, acc_db_reg};
            REG_ACC_PT: rd_next = acc_pt_reg;
            REG_ACC: rd_next = acc_reg;
            REG_CAL: rd_next = {16'h0, cal_reg};
            REG_STATUS: rd_next = {24'h0, in_svc_reg, beyond_hi, beyond_lo,
                                   acc_alert_reg, al_act};
            REG_ISTAT: rd_next = 32'(istat_reg);
            REG_IMASK: rd_next = 32'(imask_reg);
            REG_TRAVEL: rd_next = {16'h0, trv_reg};
            REG_DRIVE: rd_next = {16'h0, drive_reg};
            default:
                for (int i = 0; i < NUM_AL; i++)
                    if (paddr == REG_AL_BASE + 8'(4 * i))
                        rd_next = {16'h0, al_pt_reg[i]};
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= '0;
        else if (ce && psel && !penable)
            prdata_reg <= rd_next;
    end

    // Outputs; the slave answers with no wait state
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = acc_ph && !addr_ok(paddr);
    assign drive = drive_reg;
    assign irq = irq_reg;

endmodule : vts_supervisor

// File: test/vts_plant.sv
// Loop and sensor pin model: codes follow the bench one edge late.
`timescale 1ns/100ps
module vts_plant
    import vts_pkg::*;
(
    input wire logic pclk, // Clock
    input vts_pos_t sp_cmd, // Wanted set point
    input vts_pos_t tv_cmd, // Wanted travel
    output logic [15:0] ain_code, // Set point pin
    output logic [15:0] travel_code // Travel pin
);
    // Whole codes change at once, after an edge
    always_ff @(posedge pclk)
    begin
        ain_code <= sp_cmd;
        travel_code <= tv_cmd;
    end
endmodule : vts_plant

// File: test/vts_chk.sv
// Port checker, bound to every supervisor instance.
`timescale 1ns/100ps
module vts_chk
    import vts_pkg::*;
#(parameter int unsigned UPD_CYCLES = 8)
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic ce, // Enable
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] prdata, // Read data
    input wire logic pslverr, // Error
    input wire logic [15:0] drive // Drive
);
    wire acc = psel && penable; // Access phase
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_idle: assert property (!acc |-> !pslverr) else $error("idle");
    a_err_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("align");
    a_err_range: assert property (acc && paddr > 8'h54 |-> pslverr)
        else $error("range");
    a_map_ok: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h54
        |-> !pslverr) else $error("map");
    a_err_zero: assert property (acc && pslverr && !pwrite |->
        prdata == 32'h0) else $error("zero");
    a_rd_hold: assert property (acc |=> $stable(prdata)) else $error("rd");
    a_drive_hold: assert property
        ($changed(drive) |=> $stable(drive)[*7]) else $error("drive");
    a_ce_freeze: assert property (!$past(ce) |-> $stable(drive))
        else $error("ce");
endmodule : vts_chk
bind vts_supervisor vts_chk #(.UPD_CYCLES(UPD_CYCLES)) i_chk (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .drive(drive));

// File: test/tb_top.sv
// Bench: APB sequences against the supervisor and its pin model.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top
    import vts_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0;
    logic penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] ain_code, travel_code, drive;
    vts_pos_t sp = 16'sh0000, tv = 16'sh0000;
    int err_total = 0, checked = 0;
    always #2.5 pclk = ~pclk;
    vts_supervisor #(.UPD_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ain_code(ain_code), .travel_code(travel_code),
        .drive(drive), .irq(irq));
    vts_plant i_plant (.pclk(pclk), .sp_cmd(sp), .tv_cmd(tv),
        .ain_code(ain_code), .travel_code(travel_code));
    // One APB transfer; answer left in rd and er
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("reg", e, rd)
    endtask : rdc
    // Wait whole control updates, then settle
    task automatic wt(input int u);
        repeat (u * 8) @(posedge pclk);
        #1;
    endtask : wt
    task automatic stop_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // Watchdog
    initial
    begin
        #50000;
        err_total++;
        stop_test;
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(REG_MODE, 32'h1);
        rdc(REG_ACC_PT, 32'hFFFFFFFF);
        apb(1'b0, 8'h58, 32'h0);
        `CHK("slverr", 1'b1, er)
        sp <= 16'sh07D0;
        tv <= 16'sh07D0;
        ce <= 1'b0;
        wt(4);
        `CHK("frozen", 16'h0000, drive)
        ce <= 1'b1;
        wt(6);
        `CHK("drive", 16'h07D0, drive)
        apb(1'b1, REG_MODE, 32'h0);
        sp <= 16'sh0BB8;
        wt(6);
        `CHK("hold", 16'h07D0, drive)
        apb(1'b1, REG_MODE, 32'h3);
        rdc(REG_MODE, 32'h0);
        apb(1'b1, REG_IMASK, 32'h80);
        wt(1);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, REG_ISTAT, 32'h80);
        apb(1'b1, REG_MODE, 32'h1);
        wt(6);
        `CHK("irq", 1'b0, irq)
        `CHK("drive", 16'h0BB8, drive)
        apb(1'b1, REG_PROT, 32'h1);
        apb(1'b1, REG_MIN_OPEN, 32'h2);
        rdc(REG_MIN_OPEN, 32'h0);
        apb(1'b1, REG_PROT, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, i ? REG_MIN_CLOSE : REG_MIN_OPEN, 32'h2);
            rdc(i ? REG_MIN_CLOSE : REG_MIN_OPEN, 32'h2);
            sp <= i ? 16'sh0BB8 : 16'sh0BC2;
            wt(10);
            `CHK("ramp", 1'b1, drive !== 16'(sp))
            wt(25);
            `CHK("ramp", 16'(sp), drive)
        end
        apb(1'b1, REG_CUT_HI, 32'h0DAC);
        tv <= 16'sh0FA0;
        wt(4);
        `CHK("cut", 16'h2710, drive)
        apb(1'b1, REG_ZCS, 32'h1);
        wt(2);
        `CHK("cut", 16'h0000, drive)
        apb(1'b1, REG_ACC, 32'h0);
        tv <= 16'sh10CC;
        wt(4);
        rdc(REG_ACC, 32'h0);
        tv <= 16'sh125C;
        wt(4);
        rdc(REG_ACC, 32'h2BC);
        apb(1'b1, REG_ACC_PT, 32'h258);
        wt(1);
        rdc(REG_STATUS, 32'hD0);
        apb(1'b1, REG_ACC, 32'h0);
        wt(1);
        rdc(REG_STATUS, 32'hC0);
        apb(1'b1, REG_AL_BASE, 32'h1194);
        wt(1);
        rdc(REG_STATUS, 32'hC1);
        tv <= 16'sh0F9F;
        wt(4);
        rdc(REG_STATUS, 32'hD0);
        stop_test;
    end
endmodule : tb_top
